// >>> src/ref_level_pkg.sv
package ref_level_pkg;
  // =====================================================
  // command word layout
  localparam int WORD_BITS = 16;
  localparam int TEST_BIT_POS = 15;
  localparam int CLOCK_SOURCE_POS = 14;
  localparam int ADDR_MSB = 13;
  localparam int ADDR_LSB = 10;
  localparam int LEVEL_MSB = 9;
  localparam int LEVEL_LSB = 0;
  localparam int LEVEL_BITS = 10;
  localparam int ADDR_BITS = 4;
  localparam int CHANNELS = 12;
  // =====================================================
  // reset values
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [9:0] LEVEL_RESET = 10'h000;
  localparam logic CLOCK_SOURCE_RESET = 1'b0;
  // =====================================================
  // timing
  localparam int SYS_CLK_MHZ = 250;
  localparam int SHIFT_CLK_MAX_KHZ = 5000;
  localparam int SHIFT_HALF_CYCLES = (SYS_CLK_MHZ * 1000 + 2 * SHIFT_CLK_MAX_KHZ - 1)
                                     / (2 * SHIFT_CLK_MAX_KHZ);
  localparam int OSC_KHZ = 21;
  localparam int OSC_HALF_CYCLES = (SYS_CLK_MHZ * 1000) / (2 * OSC_KHZ);
  localparam int SETTLE_CYCLES = 8;
endpackage

// >>> src/ref_level_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ref_level_if;
  logic loadEnableN;
  logic shiftClk;
  logic serialIn;
  logic serialOut;
  logic oscOut;
  logic oscOeN;
  logic oscIn;
  modport device (
    input loadEnableN,
    input shiftClk,
    input serialIn,
    output serialOut,
    output oscOut,
    output oscOeN,
    input oscIn
  );
  modport host (
    output loadEnableN,
    output shiftClk,
    output serialIn,
    input serialOut
  );
endinterface
`default_nettype wire

// >>> src/ref_level_device.sv
// Function
// - shift serial_in on rising clock while enabled
// - words travel msb first
// - load_enable_n rise updates addressed channel
// - shift clock ignored while load enable high
// - host holds clock low before enabling
// - serial_out from register end, falling edge
// - chain of m devices takes 16m bits
// - all chained devices update together
// - host does not force a zero test bit; the host passes bit 15 of each word as given
// - bit 14 picks internal or external clock
// - bits 13..10 binary channel index
// - bits 9..0 unsigned level code
// - extra bits: last sixteen are used
// - shift clock up to 5MHz
// - shutdown high disables, floating operates
// - refresh pin input external, output internal
// - start internal, pin high impedance until loaded
// - internal oscillator near 21kHz, refresh edges
`timescale 1ns/1ps
`default_nettype none
module ref_level_device #(
  parameter int OSC_HALF = ref_level_pkg::OSC_HALF_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  ref_level_if.device link,
  input wire logic shutdownPin,
  output logic [ref_level_pkg::CHANNELS*ref_level_pkg::LEVEL_BITS-1:0] channelLevels,
  output logic clockSourceExt,
  output logic refreshClk,
  output logic refreshStrobe,
  output logic chipEnabled
);
  // =====================================================
  // input synchronisers
  logic [1:0] enaSync, clkSync, dinSync, oscSync, shdnSync;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      enaSync <= 2'h3;
      clkSync <= 2'h0;
      dinSync <= 2'h0;
      oscSync <= 2'h0;
      shdnSync <= 2'h0;
    end else begin
      enaSync <= {enaSync[0], link.loadEnableN};
      clkSync <= {clkSync[0], link.shiftClk};
      dinSync <= {dinSync[0], link.serialIn};
      oscSync <= {oscSync[0], link.oscIn};
      shdnSync <= {shdnSync[0], shutdownPin};
    end
  end
  wire enaN = enaSync[1];
  wire sclk = clkSync[1];
  wire serial_in = dinSync[1];
  wire oscExtIn = oscSync[1];
  // floating pin is pulled low by the pad, so only a driven high disables
  wire shutdown = shdnSync[1];
  // =====================================================
  // edge detection
  logic sclkPrev, enaPrev, oscPrev;
  logic oscInt;
  // external refresh clock shares the pin synchroniser, so its edges lag by two cycles
  wire refClkMux = clockSourceExt ? oscExtIn : oscInt;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkPrev <= 1'b0;
      enaPrev <= 1'b1;
      oscPrev <= 1'b0;
    end else begin
      sclkPrev <= sclk;
      enaPrev <= enaN;
      oscPrev <= refClkMux;
    end
  end
  wire sclkRise = sclk && !sclkPrev && !enaN;
  wire sclkFall = !sclk && sclkPrev && !enaN;
  wire loadRise = enaN && !enaPrev;
  // =====================================================
  // shift register, msb enters first and walks toward bit 15
  logic [15:0] shiftReg;
  logic [4:0] bitCount;
  logic sdoReg;
  wire [15:0] next_shiftReg = {shiftReg[14:0], serial_in};
  wire fullWord = bitCount >= 5'(ref_level_pkg::WORD_BITS);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shiftReg <= ref_level_pkg::SHIFT_RESET;
      bitCount <= 5'h00;
      sdoReg <= 1'b0;
    end else if (shutdown) begin
      bitCount <= 5'h00;
    end else begin
      if (sclkRise) begin
        shiftReg <= next_shiftReg;
        if (!fullWord) begin
          bitCount <= bitCount + 5'h01;
        end
      end
      if (sclkFall) begin
        sdoReg <= shiftReg[15];
      end
      if (loadRise) begin
        bitCount <= 5'h00;
      end
    end
  end
  // =====================================================
  // word decode
  wire [3:0] wordAddr = shiftReg[ref_level_pkg::ADDR_MSB:ref_level_pkg::ADDR_LSB];
  wire [9:0] wordLevel = shiftReg[ref_level_pkg::LEVEL_MSB:ref_level_pkg::LEVEL_LSB];
  wire wordClkSrc = shiftReg[ref_level_pkg::CLOCK_SOURCE_POS];
  // a short word is dropped rather than half-applied
  wire doLoad = loadRise && fullWord && !shutdown;
  wire addrValid = wordAddr < 4'(ref_level_pkg::CHANNELS);
  // =====================================================
  // channel latches
  logic [9:0] levelLatch [ref_level_pkg::CHANNELS];
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < ref_level_pkg::CHANNELS; i++) begin
        levelLatch[i] <= ref_level_pkg::LEVEL_RESET;
      end
    end else if (doLoad && addrValid) begin
      levelLatch[wordAddr] <= wordLevel;
    end
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clockSourceExt <= ref_level_pkg::CLOCK_SOURCE_RESET;
    end else if (doLoad) begin
      clockSourceExt <= wordClkSrc;
    end
  end
  // =====================================================
  // internal refresh oscillator
  logic [15:0] oscCount;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oscCount <= 16'h0000;
      oscInt <= 1'b0;
    end else if (oscCount >= 16'(OSC_HALF - 1)) begin
      oscCount <= 16'h0000;
      oscInt <= !oscInt;
    end else begin
      oscCount <= oscCount + 16'h0001;
    end
  end
  wire refFall = oscPrev && !refClkMux;
  // =====================================================
  // registered outputs
  logic internalDriveArmed;
  logic oscOutReg, oscOeNReg;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oscOutReg <= 1'b0;
      oscOeNReg <= 1'b1;
      refreshClk <= 1'b0;
      refreshStrobe <= 1'b0;
      chipEnabled <= 1'b0;
      channelLevels <= '0;
    end else begin
      oscOutReg <= oscInt;
      // pin stays released after reset until a word picks internal explicitly
      oscOeNReg <= clockSourceExt || !internalDriveArmed || shutdown;
      refreshClk <= refClkMux && !shutdown;
      refreshStrobe <= refFall && !shutdown;
      chipEnabled <= !shutdown;
      for (int i = 0; i < ref_level_pkg::CHANNELS; i++) begin
        channelLevels[i*10 +: 10] <= levelLatch[i];
      end
    end
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      internalDriveArmed <= 1'b0;
    end else if (doLoad) begin
      internalDriveArmed <= 1'b1;
    end
  end
  assign link.serialOut = sdoReg;
  assign link.oscOut = oscOutReg;
  assign link.oscOeN = oscOeNReg;
endmodule // ref_level_device
`default_nettype wire

// >>> src/ref_level_host.sv
`timescale 1ns/1ps
`default_nettype none
module ref_level_host #(
  parameter int MAX_WORDS = 4,
  parameter int HALF_CYCLES = ref_level_pkg::SHIFT_HALF_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  ref_level_if.host link,
  input wire logic startReq,
  input wire logic [7:0] wordCount,
  input wire logic [MAX_WORDS*16-1:0] words,
  output logic busy,
  output logic done
);
  // =====================================================
  // sequencer: the word of the last index goes first so it lands farthest; words[15:0] goes last
  typedef enum logic [2:0] {IDLE, SETUP, LOW, HIGH, FINISH} state_t;
  state_t state;
  logic [7:0] timer;
  logic [11:0] bitsLeft;
  logic [MAX_WORDS*16-1:0] shiftOut;
  logic enaN, sclk, serial_out;
  wire timerDone = timer == 8'h00;
  wire [11:0] totalBits = {wordCount[7:0], 4'h0};
  wire [7:0] halfLoad = 8'(HALF_CYCLES - 1);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= IDLE;
      timer <= 8'h00;
      bitsLeft <= 12'h000;
      shiftOut <= '0;
      enaN <= 1'b1;
      sclk <= 1'b0;
      serial_out <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!timerDone) begin
        timer <= timer - 8'h01;
      end
      case (state)
        IDLE: begin
          sclk <= 1'b0;
          if (startReq && wordCount != 8'h00) begin
            // chain data assumed to carry zero in each test bit
            shiftOut <= words << ((MAX_WORDS * 16) - totalBits);
            bitsLeft <= totalBits;
            enaN <= 1'b0;
            busy <= 1'b1;
            timer <= halfLoad;
            state <= SETUP;
          end
        end
        SETUP, HIGH: begin
          if (timerDone) begin
            sclk <= 1'b0;
            if (bitsLeft == 12'h000) begin
              timer <= halfLoad;
              state <= FINISH;
            end else begin
              serial_out <= shiftOut[MAX_WORDS*16-1];
              shiftOut <= shiftOut << 1;
              bitsLeft <= bitsLeft - 12'h001;
              timer <= halfLoad;
              state <= LOW;
            end
          end
        end
        LOW: begin
          if (timerDone) begin
            sclk <= 1'b1;
            timer <= halfLoad;
            state <= HIGH;
          end
        end
        FINISH: begin
          if (timerDone) begin
            enaN <= 1'b1;
            busy <= 1'b0;
            done <= 1'b1;
            state <= IDLE;
          end
        end
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end
  assign link.loadEnableN = enaN;
  assign link.shiftClk = sclk;
  assign link.serialIn = serial_out;
endmodule // ref_level_host
`default_nettype wire

// >>> test/ref_level_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ref_level_monitor (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic loadEnableN,
  input wire logic shiftClk,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic oscOeN
);
  // ====================================
  // helpers: clock run length, rises per frame
  logic prevClk;
  logic prevEna;
  logic [7:0] runLen;
  logic [7:0] rises;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prevClk <= 1'b0;
      prevEna <= 1'b1;
      runLen <= 8'h00;
      rises <= 8'h00;
    end else begin
      prevClk <= shiftClk;
      prevEna <= loadEnableN;
      runLen <= (shiftClk != prevClk) ? 8'h00 : runLen + {7'h00, runLen != 8'hFF};
      rises <= (prevEna && !loadEnableN) ? 8'h00
             : rises + {7'h00, shiftClk && !prevClk && !loadEnableN};
    end
  end
  // ====================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_idle_sdo_hold: assert property (loadEnableN [*8] |=> $stable(serialOut))
    else $error("serial out moved while idle");
  a_sdo_after_fall: assert property ($changed(serialOut) |-> !shiftClk && !loadEnableN)
    else $error("serial out moved outside a low clock");
  a_clk_low_start: assert property ($fell(loadEnableN) |-> !shiftClk && !$past(shiftClk))
    else $error("frame opened with clock high");
  a_half_period: assert property (shiftClk != prevClk |-> runLen >= 8'h18)
    else $error("shift clock too fast");
  a_data_steady: assert property ($rose(shiftClk) && !loadEnableN |-> $stable(serialIn) ##1 $stable(serialIn))
    else $error("data moved at rising clock");
  a_whole_words: assert property ($rose(loadEnableN) |-> rises != 8'h00 && rises[3:0] == 4'h0)
    else $error("frame not whole words");
  a_test_bit_zero: assert property ($rose(shiftClk) && !loadEnableN && rises[3:0] == 4'h0 |-> !serialIn)
    else $error("test bit set");
  a_osc_mode_load: assert property ($changed(oscOeN) |-> loadEnableN)
    else $error("pin mode changed mid frame");
endmodule // ref_level_monitor
`default_nettype wire

// >>> test/reference_level_serial_programmer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module reference_level_serial_programmer_tb_top;
  logic sys_clk;
  logic arst_n;
  logic shutdownPin;
  logic startReq;
  logic [7:0] wordCount;
  logic [63:0] words;
  logic done;
  logic [119:0] levels;
  logic [119:0] levels2;
  logic [119:0] saved;
  logic [31:0] got;
  logic clockSourceExt;
  logic chipEnabled;
  logic busy;
  logic refreshClk;
  logic refreshStrobe;
  logic refWas;
  int miscompares;
  int testsRun;
  int cyc;
  // ====================================
  // links: lnk host to device, lnk2 bench to second device
  ref_level_if lnk();
  ref_level_if lnk2();
  // released refresh pin sits at its pull-up
  assign lnk.oscIn = lnk.oscOeN ? 1'b1 : lnk.oscOut;
  assign lnk2.oscIn = lnk2.oscOeN ? 1'b1 : lnk2.oscOut;
  ref_level_host #(.MAX_WORDS(4)) ref_level_host_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .link(lnk), .startReq(startReq), .wordCount(wordCount), .words(words), .busy(busy),
    .done(done));
  ref_level_device #(.OSC_HALF(16)) ref_level_device_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .link(lnk), .shutdownPin(shutdownPin), .channelLevels(levels),
    .clockSourceExt(clockSourceExt), .refreshClk(refreshClk),
    .refreshStrobe(refreshStrobe), .chipEnabled(chipEnabled));
  ref_level_device #(.OSC_HALF(16)) ref_level_device_inst2 (.sys_clk(sys_clk), .arst_n(arst_n),
    .link(lnk2), .shutdownPin(1'b0), .channelLevels(levels2), .clockSourceExt(),
    .refreshClk(), .refreshStrobe(), .chipEnabled());
  ref_level_monitor ref_level_monitor_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .loadEnableN(lnk.loadEnableN), .shiftClk(lnk.shiftClk), .serialIn(lnk.serialIn),
    .serialOut(lnk.serialOut), .oscOeN(lnk.oscOeN));
  // ====================================
  // shared tasks
  task automatic check(input logic [119:0] seen, input logic [119:0] want);
    testsRun++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [9:0] lvl(input logic [119:0] v, input int ch);
    return v[ch*ref_level_pkg::LEVEL_BITS +: ref_level_pkg::LEVEL_BITS];
  endfunction
  task automatic send(input logic [7:0] n, input logic [63:0] w);
    int k;
    wordCount = n;
    words = w;
    startReq = 1'b1;
    tick(1);
    startReq = 1'b0;
    check(busy, 1'b1);
    k = 0;
    while (done !== 1'b1 && k < 5000) begin
      tick(1);
      k++;
    end
    check(done, 1'b1);
    tick(8);
  endtask
  // rule-breaking driver on lnk2; 64 ns clock only inside frames
  task automatic raw(input logic [31:0] v, input int n);
    lnk2.loadEnableN = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      lnk2.serialIn = v[i];
      tick(8);
      got = {got[30:0], lnk2.serialOut};
      lnk2.shiftClk = 1'b1;
      tick(8);
      lnk2.shiftClk = 1'b0;
    end
    tick(8);
    lnk2.loadEnableN = 1'b1;
    lnk2.serialIn = ~lnk2.serialIn;
    tick(8);
  endtask
  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ====================================
  // scenarios
  task automatic t_reset();
    check(levels, 120'h0);
    check(lnk.oscOeN, 1'b1);
    check(chipEnabled, 1'b1);
  endtask
  task automatic t_host();
    send(8'h02, 64'h0A01_2FFF);
    check(lvl(levels, 11), 10'h3FF);
    check(lvl(levels, 2), 10'h000);
    send(8'h01, 64'h5C1F);
    check(lvl(levels, 7), 10'h01F);
    check({clockSourceExt, lnk.oscOeN}, 2'h3);
    check(refreshClk, 1'b1);
    send(8'h01, 64'h0201);
    check(lvl(levels, 0), 10'h201);
    check({clockSourceExt, lnk.oscOeN}, 2'h0);
    saved = levels;
    send(8'h01, 64'h33FF);
    check(levels, saved);
  endtask
  task automatic t_raw();
    raw(32'h1555_0A5A, 32);
    check(got[15:0], 16'h1555);
    check({lvl(levels2, 2), lvl(levels2, 5)}, {10'h25A, 10'h000});
    raw(32'h0BFF, 15);
    check(lvl(levels2, 2), 10'h25A);
    got[0] = lnk2.serialOut;
    repeat (4) begin
      lnk2.shiftClk = 1'b1;
      tick(8);
      lnk2.shiftClk = 1'b0;
      tick(8);
    end
    check(lnk2.serialOut, got[0]);
  endtask
  // internal mode: one toggle per 16 cycles, one strobe per 32 with the short oscillator
  task automatic t_refresh();
    int n;
    n = 0;
    refWas = refreshClk;
    tick(16);
    check(refreshClk, !refWas);
    repeat (32) begin
      tick(1);
      n += refreshStrobe;
    end
    check(n, 1);
  endtask
  task automatic t_shutdown();
    shutdownPin = 1'b1;
    tick(8);
    check(chipEnabled, 1'b0);
    shutdownPin = 1'b0;
    tick(8);
    check(chipEnabled, 1'b1);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // hang guard: the whole run needs about 5200 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      printVerdict();
    end
  end
  initial begin
    arst_n = 1'b0;
    shutdownPin = 1'b0;
    startReq = 1'b0;
    wordCount = 8'h01;
    words = 64'h0;
    lnk2.loadEnableN = 1'b1;
    lnk2.shiftClk = 1'b0;
    lnk2.serialIn = 1'b0;
    tick(4);
    arst_n = 1'b1;
    tick(4);
    t_reset();
    t_host();
    t_refresh();
    t_raw();
    t_shutdown();
    printVerdict();
  end
endmodule // reference_level_serial_programmer_tb_top
`default_nettype wire
